// ==== rtl/mac_ctl_pkg.sv ====
// How it works
// - send_request set by software, self-clears when sent
// - tx_length_guard_off disables 2048-byte transmit cut
// - retry_forever zero abandons after sixteen collisions
// - per-slot pad suppress bits four and two
// - per-slot fcs suppress bits three and one
// - per-slot outcome flags overlength transmit cut
// - carrier_dropped on carrier loss, loopback meaningless
// - carrier_absent when carrier never seen, not in loopback
// - late collision after first 64 bytes
// - tx_clash_seen on any transmit collision
// - retry_limit_hit when abandoned after 16 collisions
// - rx_length_guard_off disables 2048-byte receive watchdog
// - drop_oversize discards frames over 1522 bytes
// - drop_bad_fcs discards frames failing check
// - undersize_frame_flag for frames under 64 bytes
// - group_address_flag for multicast destination
// - rx_late_clash on late collision while receiving
// - rx_overlength_timeout past 2048 received bytes
// - phy_symbol_fault and misaligned_end receive flags
// - frame_check_fail and rx_buffer_overrun_flag flags
// - seven-bit drop_tally, cleared by read
// - drop_tally_wrap on counter overflow, read clears
package mac_ctl_pkg;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h02;
  localparam logic [7:0] ADDR_TX_OUT1 = 8'h03;
  localparam logic [7:0] ADDR_TX_OUT2 = 8'h04;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h05;
  localparam logic [7:0] ADDR_RX_OUT = 8'h06;
  localparam logic [7:0] ADDR_DROP_CNT = 8'h07;
  // transmit control fields
  localparam int TC_SEND = 0;
  localparam int TC_NOFCS1 = 1;
  localparam int TC_NOFILL1 = 2;
  localparam int TC_NOFCS2 = 3;
  localparam int TC_NOFILL2 = 4;
  localparam int TC_RETRY = 5;
  localparam int TC_GUARD = 6;
  localparam logic [7:0] TC_WMASK = 8'h7f;
  // transmit outcome fields
  localparam int TO_CUT = 7;
  localparam int TO_DROP = 6;
  localparam int TO_ABSENT = 5;
  localparam int TO_LATE = 4;
  localparam int TO_CLASH = 3;
  localparam int TO_LIMIT = 2;
  // receive control fields
  localparam int RC_ON = 0;
  localparam int RC_ANY = 1;
  localparam int RC_RUNT = 2;
  localparam int RC_ALLGRP = 3;
  localparam int RC_BADFCS = 4;
  localparam int RC_LONG = 5;
  localparam int RC_GUARD = 6;
  // receive outcome fields
  localparam int RO_RUNT = 7;
  localparam int RO_GRP = 6;
  localparam int RO_LATE = 5;
  localparam int RO_WDOG = 4;
  localparam int RO_PHY = 3;
  localparam int RO_ALIGN = 2;
  localparam int RO_FCS = 1;
  localparam int RO_OVR = 0;
  localparam int DC_WRAP = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // byte, collision and tally limits
  localparam logic [11:0] GUARD_BYTES = 12'h800;
  localparam logic [11:0] MIN_FRAME = 12'h040;
  localparam logic [11:0] MAX_FRAME = 12'h5f2;
  localparam logic [4:0] COLL_LIMIT = 5'h10;
  localparam logic [6:0] TALLY_MAX = 7'h7f;

  typedef struct packed {
    logic start;    // first byte of a frame
    logic valid;    // one byte on the wire
    logic done;     // frame ended normally
    logic collision;
    logic carrier;
  } tx_line_t;

  typedef struct packed {
    logic start;
    logic valid;
    logic last;     // final byte of a frame
    logic fcs_bad;
    logic odd_bits;
    logic phy_err;
    logic collision;
    logic multicast;
    logic addr_hit;
    logic overrun;
  } rx_line_t;
endpackage

// ==== rtl/mac_tx_rx_control_status.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module mac_tx_rx_control_status
  import mac_ctl_pkg::*;
#(
  parameter int GUARD_LEN = 2048,
  parameter int MIN_LEN = 64,
  parameter int MAX_LEN = 1522
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire tx_line_t tx_line,
  input wire logic loopback,
  input wire rx_line_t rx_line,
  output logic tx_go_q,
  output logic tx_slot_q,
  output logic tx_no_fill_q,
  output logic tx_no_fcs_q,
  output logic tx_cut_q,
  output logic tx_retry_q,
  output logic tx_abort_q,
  output logic rx_accept_q,
  output logic rx_discard_q
);
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_SEND = 3'b010,
    T_END = 3'b100
  } tx_state_t;

  tx_state_t tx_st_q;
  logic [7:0] tctl_q;
  logic [7:0] rctl_q;
  logic [7:0] tout1_q;
  logic [7:0] tout2_q;
  logic [7:0] rout_q;
  logic [7:0] drop_q;
  logic [11:0] tx_cnt_q;
  logic [11:0] rx_cnt_q;
  logic [4:0] coll_q;
  logic [7:0] fr_q;
  logic rx_act_q;
  logic carrier_seen_q;
  logic [7:0] fr_d;
  logic rx_keep;
  logic rd_drop;
  logic wr_tctl;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign rd_drop = reg_rd && hit(reg_addr, ADDR_DROP_CNT);
  assign wr_tctl = reg_wr && hit(reg_addr, ADDR_TX_CTRL);

  // ***************************
  // register read port
  // ***************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_TX_CTRL: reg_rdata <= tctl_q;
        ADDR_TX_OUT1: reg_rdata <= tout1_q;
        ADDR_TX_OUT2: reg_rdata <= tout2_q;
        ADDR_RX_CTRL: reg_rdata <= rctl_q;
        ADDR_RX_OUT: reg_rdata <= rout_q;
        ADDR_DROP_CNT: reg_rdata <= drop_q;
        default: reg_rdata <= RESET_BYTE;
      endcase
    end else begin
      reg_rdata <= RESET_BYTE;
    end
  end

  // ***************************
  // control registers
  // ***************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rctl_q <= RESET_BYTE;
    end else if (reg_wr && hit(reg_addr, ADDR_RX_CTRL)) begin
      rctl_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tctl_q <= RESET_BYTE;
    end else begin
      if (wr_tctl) begin
        tctl_q <= reg_wdata & TC_WMASK;
      end
      if (tx_st_q == T_END && !(wr_tctl && reg_wdata[TC_SEND])) begin
        tctl_q[TC_SEND] <= 1'b0;
      end
    end
  end

  // ***************************
  // transmit sequencer
  // ***************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_st_q <= T_IDLE;
      tx_go_q <= 1'b0;
      tx_slot_q <= 1'b0;
      tx_no_fill_q <= 1'b0;
      tx_no_fcs_q <= 1'b0;
      tx_cut_q <= 1'b0;
      tx_retry_q <= 1'b0;
      tx_abort_q <= 1'b0;
      tx_cnt_q <= '0;
      coll_q <= '0;
      carrier_seen_q <= 1'b0;
      tout1_q <= RESET_BYTE;
      tout2_q <= RESET_BYTE;
    end else begin
      tx_go_q <= 1'b0;
      tx_cut_q <= 1'b0;
      tx_retry_q <= 1'b0;
      tx_abort_q <= 1'b0;
      case (tx_st_q)
        T_IDLE: begin
          if (tctl_q[TC_SEND]) begin
            tx_st_q <= T_SEND;
            tx_go_q <= 1'b1;
            tx_cnt_q <= '0;
            coll_q <= '0;
            carrier_seen_q <= 1'b0;
            if (tx_slot_q) begin
              tout2_q <= RESET_BYTE;
              tx_no_fill_q <= tctl_q[TC_NOFILL2];
              tx_no_fcs_q <= tctl_q[TC_NOFCS2];
            end else begin
              tout1_q <= RESET_BYTE;
              tx_no_fill_q <= tctl_q[TC_NOFILL1];
              tx_no_fcs_q <= tctl_q[TC_NOFCS1];
            end
          end
        end
        T_SEND: begin
          if (tx_line.start) begin
            tx_cnt_q <= '0;
          end
          if (tx_line.valid) begin
            tx_cnt_q <= tx_cnt_q + 12'h001;
            if (tx_line.carrier) begin
              carrier_seen_q <= 1'b1;
            end
          end
          if (tx_line.valid && !tx_line.carrier && !loopback && carrier_seen_q) begin
            if (tx_slot_q) tout2_q[TO_DROP] <= 1'b1;
            else tout1_q[TO_DROP] <= 1'b1;
          end
          if (tx_line.collision) begin
            coll_q <= coll_q + 5'h01;
            if (tx_slot_q) tout2_q[TO_CLASH] <= 1'b1;
            else tout1_q[TO_CLASH] <= 1'b1;
            if (tx_cnt_q >= MIN_LEN[11:0]) begin
              if (tx_slot_q) tout2_q[TO_LATE] <= 1'b1;
              else tout1_q[TO_LATE] <= 1'b1;
            end
            if (coll_q + 5'h01 >= COLL_LIMIT && !tctl_q[TC_RETRY]) begin
              tx_abort_q <= 1'b1;
              tx_st_q <= T_END;
              if (tx_slot_q) tout2_q[TO_LIMIT] <= 1'b1;
              else tout1_q[TO_LIMIT] <= 1'b1;
            end else begin
              tx_retry_q <= 1'b1;
            end
          end else if (tx_line.valid && !tctl_q[TC_GUARD]
                       && tx_cnt_q >= GUARD_LEN[11:0] - 12'h001) begin
            tx_cut_q <= 1'b1;
            tx_st_q <= T_END;
            if (tx_slot_q) tout2_q[TO_CUT] <= 1'b1;
            else tout1_q[TO_CUT] <= 1'b1;
          end else if (tx_line.done) begin
            tx_st_q <= T_END;
          end
        end
        T_END: begin
          if (!carrier_seen_q && !loopback) begin
            if (tx_slot_q) tout2_q[TO_ABSENT] <= 1'b1;
            else tout1_q[TO_ABSENT] <= 1'b1;
          end
          tx_slot_q <= ~tx_slot_q;
          tx_st_q <= T_IDLE;
        end
        default: tx_st_q <= T_IDLE;
      endcase
    end
  end

  // ***************************
  // receive filter and status
  // ***************************
  always_comb begin
    fr_d = fr_q;
    rx_keep = rctl_q[RC_ON] && (rx_line.addr_hit || rctl_q[RC_ANY]
              || (rx_line.multicast && rctl_q[RC_ALLGRP]));
    if (rx_line.start) begin
      fr_d = RESET_BYTE;
      fr_d[RO_GRP] = rx_line.multicast;
    end
    if (rx_line.valid) begin
      if (rx_line.collision && rx_cnt_q >= MIN_LEN[11:0]) fr_d[RO_LATE] = 1'b1;
      if (rx_line.multicast) fr_d[RO_GRP] = 1'b1;
      if (rx_line.phy_err) fr_d[RO_PHY] = 1'b1;
      if (rx_line.overrun) fr_d[RO_OVR] = 1'b1;
      if (rx_line.last) begin
        if (rx_cnt_q + 12'h001 < MIN_LEN[11:0]) fr_d[RO_RUNT] = 1'b1;
        if (rx_line.odd_bits) fr_d[RO_ALIGN] = 1'b1;
        if (rx_line.fcs_bad) fr_d[RO_FCS] = 1'b1;
      end
    end
    if (rx_act_q && !rctl_q[RC_GUARD] && rx_cnt_q >= GUARD_LEN[11:0]) begin
      fr_d[RO_WDOG] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fr_q <= RESET_BYTE;
      rout_q <= RESET_BYTE;
      rx_cnt_q <= '0;
      rx_act_q <= 1'b0;
      rx_accept_q <= 1'b0;
      rx_discard_q <= 1'b0;
    end else begin
      fr_q <= fr_d;
      rx_accept_q <= 1'b0;
      rx_discard_q <= 1'b0;
      if (rx_line.start) begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= '0;
      end else if (rx_line.valid && rx_cnt_q != 12'hfff) begin
        rx_cnt_q <= rx_cnt_q + 12'h001;
      end
      if (rx_line.valid && rx_line.last && rx_act_q) begin
        rx_act_q <= 1'b0;
        rout_q <= fr_d;
        if (!rx_keep
            || (rctl_q[RC_LONG] && rx_cnt_q + 12'h001 > MAX_LEN[11:0])
            || (rctl_q[RC_BADFCS] && fr_d[RO_FCS])
            || (!rctl_q[RC_RUNT] && fr_d[RO_RUNT])
            || fr_d[RO_WDOG] || fr_d[RO_OVR]) begin
          rx_discard_q <= 1'b1;
        end else begin
          rx_accept_q <= 1'b1;
        end
      end
    end
  end

  // ***************************
  // overflow drop counter
  // ***************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drop_q <= RESET_BYTE;
    end else begin
      if (rd_drop) begin
        drop_q <= RESET_BYTE;
      end
      if (rx_line.valid && rx_line.last && rx_act_q && fr_d[RO_OVR]) begin
        drop_q[6:0] <= (rd_drop ? 7'h00 : drop_q[6:0]) + 7'h01;
        if (!rd_drop && drop_q[6:0] == TALLY_MAX) begin
          drop_q[DC_WRAP] <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== test/mac_ctl_checker_assertions.sv ====
`timescale 1ns/10ps
module mac_ctl_checker
  import mac_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire tx_line_t tx_line,
  input wire rx_line_t rx_line,
  input wire logic tx_go_q,
  input wire logic tx_slot_q,
  input wire logic tx_no_fill_q,
  input wire logic tx_no_fcs_q,
  input wire logic tx_cut_q,
  input wire logic tx_abort_q,
  input wire logic rx_discard_q
);
  // *****
  // shadows of written control, collisions per frame
  // *****
  logic [7:0] tc_q;
  logic [7:0] rc_q;
  logic [4:0] coll_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tc_q <= 8'h00;
      rc_q <= 8'h00;
    end else if (reg_wr) begin
      tc_q <= (reg_addr == ADDR_TX_CTRL) ? reg_wdata : tc_q;
      rc_q <= (reg_addr == ADDR_RX_CTRL) ? reg_wdata : rc_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || tx_go_q) begin
      coll_q <= 5'h00;
    end else if (tx_line.collision && coll_q != 5'h1f) begin
      coll_q <= coll_q + 5'h01;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_unmapped;
    reg_rd && (reg_addr < ADDR_TX_CTRL || reg_addr > ADDR_DROP_CNT) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_go_pulse;
    tx_go_q |=> !tx_go_q;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start pulse too long");
  property p_slot_bits;
    tx_line.valid |-> tx_no_fill_q == tc_q[tx_slot_q ? TC_NOFILL2 : TC_NOFILL1]
      && tx_no_fcs_q == tc_q[tx_slot_q ? TC_NOFCS2 : TC_NOFCS1];
  endproperty
  a_slot_bits: assert property (p_slot_bits) else $error("slot suppress bits");
  property p_retry_forever;
    tc_q[TC_RETRY] |-> !tx_abort_q;
  endproperty
  a_retry_forever: assert property (p_retry_forever) else $error("abort while retrying");
  property p_abort_count;
    tx_abort_q |-> coll_q >= COLL_LIMIT;
  endproperty
  a_abort_count: assert property (p_abort_count) else $error("abort too early");
  property p_guard_off;
    tc_q[TC_GUARD] |-> !tx_cut_q;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("cut with guard off");
  property p_bad_fcs;
    rc_q[RC_ON] && rc_q[RC_BADFCS] && rx_line.valid && rx_line.last && rx_line.fcs_bad
      |=> rx_discard_q;
  endproperty
  a_bad_fcs: assert property (p_bad_fcs) else $error("bad frame kept");
endmodule
bind mac_tx_rx_control_status mac_ctl_checker u_chk (
  .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_line,
  .rx_line, .tx_go_q, .tx_slot_q, .tx_no_fill_q, .tx_no_fcs_q, .tx_cut_q, .tx_abort_q,
  .rx_discard_q
);

// ==== test/phy_model.sv ====
`timescale 1ns/10ps
module phy_model
  import mac_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic tx_go_q,
  input wire logic tx_cut_q,
  input wire logic tx_abort_q,
  output tx_line_t tx_line,
  output rx_line_t rx_line
);
  // *****
  // medium side frames
  // *****
  initial begin
    tx_line = '0;
    rx_line = '0;
  end
  task automatic tx_frame(input int n, lo, hi, cf, ct, output bit ok);
    int i;
    bit stop;
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge mclk);
      ok = tx_go_q;
    end
    stop = !ok;
    for (i = 0; i < n && !stop; i++) begin
      tx_line <= '{start: i == 0, valid: 1'b1, done: 1'b0,
                   collision: i >= lo && i < hi, carrier: i >= cf && i < ct};
      @(posedge mclk);
      stop = tx_cut_q || tx_abort_q;
    end
    tx_line <= '{done: !stop, default: 1'b0};
    @(posedge mclk);
    tx_line <= '0;
  endtask
  task automatic rx_frame(input int n, input rx_line_t f);
    int i;
    rx_line <= '{start: 1'b1, default: 1'b0};
    for (i = 1; i <= n; i++) begin
      @(posedge mclk);
      rx_line <= f | rx_line_t'({2'b01, i == n, 7'h00});
    end
    @(posedge mclk);
    rx_line <= '0;
  endtask
endmodule

// ==== test/mac_tx_rx_control_status_tb.sv ====
`timescale 1ns/10ps
module mac_tx_rx_control_status_tb;
  import mac_ctl_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_rd, loopback, sl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  tx_line_t tx_line;
  rx_line_t rx_line;
  logic tx_go_q, tx_slot_q, tx_no_fill_q, tx_no_fcs_q, tx_cut_q, tx_retry_q, tx_abort_q;
  logic rx_accept_q, rx_discard_q;
  int fail_count = 0;
  int n_checks = 0;
  int i;
  logic [9:0] fm [6] = '{10'h040, 10'h020, 10'h010, 10'h008, 10'h004, 10'h001};
  logic [7:0] fe [6] = '{8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h01};
  mac_tx_rx_control_status #(.GUARD_LEN(48), .MIN_LEN(32), .MAX_LEN(40)) dut (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_line,
    .loopback, .rx_line, .tx_go_q, .tx_slot_q, .tx_no_fill_q, .tx_no_fcs_q, .tx_cut_q,
    .tx_retry_q, .tx_abort_q, .rx_accept_q, .rx_discard_q
  );
  phy_model phy (.mclk, .tx_go_q, .tx_cut_q, .tx_abort_q, .tx_line, .rx_line);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
    @(posedge mclk);
  endtask
  task automatic tx(input logic [7:0] c, input int n, lo, hi, cf, ct, input logic [7:0] eo);
    bit ok;
    wr(ADDR_TX_CTRL, c);
    phy.tx_frame(n, lo, hi, cf, ct, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) tally_and_finish();
    repeat (4) @(posedge mclk);
    rc(ADDR_TX_CTRL, c & 8'h7e);
    rc(sl ? ADDR_TX_OUT2 : ADDR_TX_OUT1, eo);
    sl = !sl;
  endtask
  task automatic rx(input int n, input logic [9:0] f, input logic [7:0] eo, input logic [1:0] ad);
    phy.rx_frame(n, rx_line_t'(f));
    #1;
    if (ad != 2'b11) chk({6'h00, rx_accept_q, rx_discard_q}, {6'h00, ad});
    @(posedge mclk);
    rc(ADDR_RX_OUT, eo);
  endtask
  initial begin
    {sys_rst, reg_wr, reg_rd, loopback, sl} = 5'b10000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (i = 2; i < 9; i++) rc(8'(i), 8'h00);
    wr(ADDR_TX_CTRL, 8'hfe);
    rc(ADDR_TX_CTRL, 8'h7e);
    wr(ADDR_RX_CTRL, 8'h7e);
    rc(ADDR_RX_CTRL, 8'h7e);
    wr(ADDR_RX_OUT, 8'hff);
    rc(ADDR_RX_OUT, 8'h00);
    $display("register test done");
    tx(8'h05, 10, 2, 3, 0, 10, 8'h08);
    tx(8'h09, 40, 35, 36, 0, 0, 8'h38);
    tx(8'h01, 10, 0, 0, 0, 3, 8'h40);
    tx(8'h01, 60, 0, 0, 0, 60, 8'h80);
    tx(8'h41, 60, 0, 0, 0, 60, 8'h00);
    tx(8'h01, 24, 0, 20, 0, 24, 8'h0c);
    tx(8'h21, 24, 0, 20, 0, 24, 8'h08);
    loopback <= 1'b1;
    tx(8'h01, 10, 0, 0, 0, 3, 8'h00);
    loopback <= 1'b0;
    $display("transmit test done");
    wr(ADDR_RX_CTRL, 8'h01);
    rx(36, 10'h002, 8'h00, 2'b10);
    rx(10, 10'h002, 8'h80, 2'b11);
    rx(50, 10'h002, 8'h10, 2'b11);
    for (i = 0; i < 6; i++) rx(36, fm[i] | 10'h002, fe[i], 2'b11);
    wr(ADDR_RX_CTRL, 8'h41);
    rx(50, 10'h002, 8'h00, 2'b11);
    wr(ADDR_RX_CTRL, 8'h21);
    rx(44, 10'h002, 8'h00, 2'b01);
    wr(ADDR_RX_CTRL, 8'h11);
    rx(36, 10'h042, 8'h02, 2'b01);
    wr(ADDR_RX_CTRL, 8'h01);
    rx(44, 10'h002, 8'h00, 2'b10);
    rx(36, 10'h042, 8'h02, 2'b10);
    rc(ADDR_DROP_CNT, 8'h01);
    rc(ADDR_DROP_CNT, 8'h00);
    for (i = 0; i < 130; i++) begin
      phy.rx_frame(2, rx_line_t'(10'h003));
      @(posedge mclk);
    end
    rc(ADDR_DROP_CNT, 8'h82);
    rc(ADDR_DROP_CNT, 8'h00);
    $display("receive test done");
    tally_and_finish();
  end
endmodule
